// file: drc_refresh_ctrl.sv
// drc_refresh_ctrl: row compare, precharge select and cas-before-ras refresh with apb registers
// Functional notes
// - 11-bit shift compares A23..A11 or A23..A12
// - 8-bit shift compares A23..A8/A9, precharge A15..A9
// - 9-bit shift compares A23..A9/A10, precharge A15..A10
// - 10-bit shift compares A23..A10/A11, precharge A15..A11
// - refresh drops column strobe before row strobe
// - standby can put dram into self refresh
// - refresh only while some area is dram
// - cbr refresh only when refresh enable set
// - counter matches constant, refreshes, restarts at zero
// - counter starts when clock select nonzero
// - mode zero lets non-dram accesses run
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module drc_refresh_ctrl
#(
  parameter int unsigned ROW_W = 24             // external address width
) (
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [drc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    accValid,   // one-cycle access strobe
  input  wire logic [ROW_W-1:0]        accAddr,    // access address
  input  wire logic                    accDram,    // access targets dram space
  input  wire logic                    standbyIn,  // software standby level
  output logic                         sameRow_q,  // access hits the open row
  output logic      [6:0]              prechSel_q, // column A15..A9 used as precharge select
  output logic                         casN_q,     // column strobe, active low
  output logic                         rasN_q,     // row strobe, active low
  output logic                         dramHold_q, // dram accesses must wait
  output logic                         extHold_q,  // all external accesses must wait
  output logic                         selfRef_q   // dram is in self refresh
);
  import drc_pkg::*;
  // compared row bits for a shift code and space width; zero mask means no compare
  function automatic logic [ROW_W-1:0] rowMask(input logic [2:0] sh, input logic b16);
    logic [4:0] low;
    low = 5'h00;
    case (sh)
      SHIFT_11: low = b16 ? 5'd12 : 5'd11;
      SHIFT_8:  low = b16 ? 5'd9  : 5'd8;
      SHIFT_9:  low = b16 ? 5'd10 : 5'd9;
      SHIFT_10: low = b16 ? 5'd11 : 5'd10;
      default:  low = 5'h00;
    endcase
    rowMask = (low == 5'h00) ? '0 : ({ROW_W{1'b1}} << low);
  endfunction
  // column bits A15..A9 that act as precharge select, sdram codes only
  function automatic logic [6:0] prechMask(input logic [2:0] sh);
    case (sh)
      SHIFT_8:  prechMask = 7'h7F;
      SHIFT_9:  prechMask = 7'h7E;
      SHIFT_10: prechMask = 7'h7C;
      default:  prechMask = 7'h00;
    endcase
  endfunction
  // prescaler tap for a clock select code; code zero never ticks
  function automatic logic preTick(input logic [2:0] sel, input logic [11:0] pre);
    case (sel)
      3'h1:    preTick = &pre[0:0];
      3'h2:    preTick = &pre[2:0];
      3'h3:    preTick = &pre[4:0];
      3'h4:    preTick = &pre[6:0];
      3'h5:    preTick = &pre[8:0];
      3'h6:    preTick = &pre[10:0];
      3'h7:    preTick = &pre[11:0];
      default: preTick = 1'b0;
    endcase
  endfunction
  logic [6:0]       dramCtrl_q;   // dram_control_register
  logic [5:0]       refCtrl_q;    // refresh_control_register
  logic [7:0]       count_q;      // refresh_timer_count
  logic [7:0]       const_q;      // refresh_time_constant
  logic [11:0]      pre_q;        // prescaler, held at zero while clock select is zero
  logic             refPend_q;    // refresh requested, not yet started
  logic             selfMode_q;   // current strobe cycle is self refresh
  logic [ROW_W-1:0] lastRow_q;    // last dram access address
  logic             rowOpen_q;    // lastRow_q holds a valid open row
  drc_state_e       state_q;
  drc_state_e       stateD;
  logic [3:0]       phase_q;      // cycles spent in current state
  // decoded control fields
  logic [2:0] rowShift;
  logic       bus16;
  logic       dramSpace;
  logic [2:0] clkSel;
  logic       refEn;
  logic       refMode;
  logic       selfEn;
  assign rowShift  = dramCtrl_q[ROW_SHIFT_LSB +: 3];
  assign bus16     = dramCtrl_q[BUS16_BIT];
  assign dramSpace = |dramCtrl_q[SPACE_LSB +: 3];
  assign clkSel    = refCtrl_q[CLK_SEL_LSB +: 3];
  assign refEn     = refCtrl_q[REF_EN_BIT];
  assign refMode   = refCtrl_q[REF_MODE_BIT];
  assign selfEn    = refCtrl_q[SELF_EN_BIT];
  // apb strobes; a write lands only on the completing access edge
  logic wrEn;
  logic cntWr;
  logic tick;
  logic match;
  logic selfGo;
  assign wrEn   = psel && penable && pwrite && pready;
  assign cntWr  = wrEn && (paddr == OFS_COUNT);
  assign tick   = preTick(clkSel, pre_q);
  assign match  = tick && (count_q == const_q) && !cntWr;
  assign selfGo = standbyIn && selfEn && dramSpace;
  // apb answer: ready one cycle after setup, so every access has one wait-free access phase
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        // read data is fixed at setup; counter may move before the access edge
        case (paddr)
          OFS_DRAM_CTRL: prdata <= {25'h0, dramCtrl_q};
          OFS_REF_CTRL:  prdata <= {26'h0, refCtrl_q};
          OFS_COUNT:     prdata <= {24'h0, count_q};
          OFS_CONST:     prdata <= {24'h0, const_q};
          OFS_STATUS:    prdata <= {29'h0, refPend_q, selfRef_q, (state_q != ST_IDLE)};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1; // unmapped offset
          end
        endcase
      end
    end
  end
  // control registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dramCtrl_q <= DRAM_CTRL_RST;
      refCtrl_q  <= REF_CTRL_RST;
      const_q    <= CONST_RST;
    end else if (wrEn) begin
      if (paddr == OFS_DRAM_CTRL) dramCtrl_q <= pwdata[6:0];
      if (paddr == OFS_REF_CTRL)  refCtrl_q  <= pwdata[5:0];
      if (paddr == OFS_CONST)     const_q    <= pwdata[7:0];
    end
  end
  // prescaler runs only while a clock is selected, so the first count is a full period
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pre_q <= 12'h000;
    end else if (clkSel == 3'h0) begin
      pre_q <= 12'h000;
    end else begin
      pre_q <= pre_q + 12'h001;
    end
  end
  // refresh timer: software write wins over counting
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_q <= COUNT_RST;
    end else if (cntWr) begin
      count_q <= pwdata[7:0];
    end else if (match) begin
      count_q <= 8'h00;
    end else if (tick) begin
      count_q <= count_q + 8'h01;
    end
  end
  // pending request; a new match in the start cycle wins over the clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      refPend_q <= 1'b0;
    end else if (match && refEn && dramSpace) begin
      refPend_q <= 1'b1;
    end else if (!dramSpace || !refEn) begin
      refPend_q <= 1'b0;
    end else if (state_q == ST_IDLE && stateD == ST_CAS && !selfGo) begin
      refPend_q <= 1'b0;
    end
  end
  // sequencer next state
  always_comb begin
    stateD = state_q;
    case (state_q)
      ST_IDLE: begin
        // a stale request must not start once enable or dram space has gone
        if (selfGo || (refPend_q && refEn && dramSpace)) stateD = ST_CAS;
      end
      ST_CAS: begin
        if (phase_q + 4'h1 >= CAS_LEAD_CYC) stateD = ST_RAS;
      end
      ST_RAS: begin
        if (selfMode_q) begin
          if (!standbyIn) stateD = ST_RECOVER;
        end else if (phase_q + 4'h1 >= RAS_LOW_CYC) begin
          stateD = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (phase_q + 4'h1 >= PRECH_CYC) stateD = ST_IDLE;
      end
      default: stateD = ST_IDLE;
    endcase
  end

  // sequencer state, phase count and self refresh flag
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      phase_q    <= 4'h0;
      selfMode_q <= 1'b0;
    end else begin
      state_q <= stateD;
      phase_q <= (stateD != state_q) ? 4'h0 : phase_q + 4'h1;
      if (state_q == ST_IDLE && stateD == ST_CAS) selfMode_q <= selfGo;
      else if (stateD == ST_IDLE) selfMode_q <= 1'b0;
    end
  end

  // strobes and holds registered from the next state so they line up with state_q
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      casN_q     <= 1'b1;
      rasN_q     <= 1'b1;
      dramHold_q <= 1'b0;
      extHold_q  <= 1'b0;
      selfRef_q  <= 1'b0;
    end else begin
      casN_q     <= !(stateD == ST_CAS || stateD == ST_RAS);
      rasN_q     <= !(stateD == ST_RAS);
      dramHold_q <= (stateD != ST_IDLE);
      // mode zero frees non-dram space during the refresh
      extHold_q  <= (stateD != ST_IDLE) && refMode;
      selfRef_q  <= (stateD == ST_RAS) && (selfMode_q || (state_q == ST_IDLE && selfGo));
    end
  end

  // row compare and precharge select; a refresh closes the open row
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sameRow_q  <= 1'b0;
      prechSel_q <= 7'h00;
      lastRow_q  <= '0;
      rowOpen_q  <= 1'b0;
    end else if (state_q == ST_RAS) begin
      sameRow_q <= 1'b0;
      rowOpen_q <= 1'b0;
    end else if (accValid && accDram) begin
      sameRow_q  <= rowOpen_q && (rowMask(rowShift, bus16) != '0)
                    && (((accAddr ^ lastRow_q) & rowMask(rowShift, bus16)) == '0);
      prechSel_q <= accAddr[15:9] & prechMask(rowShift);
      lastRow_q  <= accAddr;
      rowOpen_q  <= 1'b1;
    end
  end
  property p_row11;
    @(posedge clk_sys) disable iff (!nrst)
    (accValid && accDram && rowShift == SHIFT_11 && !bus16 && rowOpen_q && state_q != ST_RAS
     && accAddr[23:11] == lastRow_q[23:11]) |=> sameRow_q;
  endproperty
  a_row11: assert property (p_row11) else $error("11-bit shift row hit missed");
  property p_row8;
    @(posedge clk_sys) disable iff (!nrst)
    (accValid && accDram && rowShift == SHIFT_8 && state_q != ST_RAS)
      |=> prechSel_q == $past(accAddr[15:9]);
  endproperty
  a_row8: assert property (p_row8) else $error("8-bit shift precharge select wrong");
  property p_row9;
    @(posedge clk_sys) disable iff (!nrst)
    (accValid && accDram && rowShift == SHIFT_9 && bus16 && rowOpen_q && state_q != ST_RAS
     && accAddr[9] != lastRow_q[9] && accAddr[23:10] == lastRow_q[23:10])
      |=> sameRow_q && prechSel_q[0] == 1'b0;
  endproperty
  a_row9: assert property (p_row9) else $error("9-bit shift compare wrong");
  property p_row10;
    @(posedge clk_sys) disable iff (!nrst)
    (accValid && accDram && rowShift == SHIFT_10 && !bus16 && rowOpen_q && state_q != ST_RAS
     && accAddr[10] != lastRow_q[10]) |=> !sameRow_q && prechSel_q[1:0] == 2'b00;
  endproperty
  a_row10: assert property (p_row10) else $error("10-bit shift compare wrong");
  property p_casFirst;
    @(posedge clk_sys) disable iff (!nrst)
    $fell(rasN_q) |-> !casN_q && !$past(casN_q);
  endproperty
  a_casFirst: assert property (p_casFirst) else $error("ras fell without cas lead");
  property p_selfEnter;
    @(posedge clk_sys) disable iff (!nrst)
    (selfGo && state_q == ST_IDLE) ##1 standbyIn[*3] |-> selfRef_q;
  endproperty
  a_selfEnter: assert property (p_selfEnter) else $error("self refresh not entered");
  property p_needDram;
    @(posedge clk_sys) disable iff (!nrst)
    $fell(casN_q) |-> $past(dramSpace);
  endproperty
  a_needDram: assert property (p_needDram) else $error("refresh without dram space");
  property p_needEn;
    @(posedge clk_sys) disable iff (!nrst)
    ($fell(casN_q) && !$past(selfGo)) |-> $past(refEn);
  endproperty
  a_needEn: assert property (p_needEn) else $error("cbr refresh while disabled");
  property p_wrap;
    @(posedge clk_sys) disable iff (!nrst)
    match |=> count_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not restart at zero");
  property p_start;
    @(posedge clk_sys) disable iff (!nrst)
    ($rose(clkSel != 3'h0) && clkSel == 3'h1 && !cntWr && count_q != const_q)
      ##1 !cntWr |=> count_q == $past(count_q, 2) + 8'h01;
  endproperty
  a_start: assert property (p_start) else $error("counter did not start");
  property p_par;
    @(posedge clk_sys) disable iff (!nrst)
    !refMode |=> !extHold_q;
  endproperty
  a_par: assert property (p_par) else $error("non-dram access held in mode zero");
  property p_hold;
    @(posedge clk_sys) disable iff (!nrst)
    (state_q != ST_IDLE && refMode) |-> extHold_q || !$past(refMode);
  endproperty
  a_hold: assert property (p_hold) else $error("external access not held");
  property p_freeze;
    @(posedge clk_sys) disable iff (!nrst)
    (clkSel == 3'h0 && !cntWr) |=> $stable(count_q) && !$rose(refPend_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while stopped");
endmodule // drc_refresh_ctrl
`default_nettype wire

// file: drc_pkg.sv
// drc_pkg: register map, field layout, codes and timing for the dram row compare and refresh block
package drc_pkg;
  // apb address width used by the register decoder
  localparam int unsigned     ADDR_W        = 8;
  // register byte offsets, one aligned word each
  localparam logic [7:0]      OFS_DRAM_CTRL = 8'h00;  // dram_control_register
  localparam logic [7:0]      OFS_REF_CTRL  = 8'h04;  // refresh_control_register
  localparam logic [7:0]      OFS_COUNT     = 8'h08;  // refresh_timer_count
  localparam logic [7:0]      OFS_CONST     = 8'h0C;  // refresh_time_constant
  localparam logic [7:0]      OFS_STATUS    = 8'h10;  // read-only state
  // dram_control_register fields
  localparam int unsigned     ROW_SHIFT_LSB = 0;      // row_shift_sel_2..0
  localparam int unsigned     SPACE_LSB     = 3;      // dram_space_type_2..0
  localparam int unsigned     BUS16_BIT     = 6;      // 1: 16-bit access space
  // refresh_control_register fields
  localparam int unsigned     CLK_SEL_LSB   = 0;      // refresh_clock_sel_2..0
  localparam int unsigned     REF_EN_BIT    = 3;      // refresh_enable_bit
  localparam int unsigned     REF_MODE_BIT  = 4;      // refresh_mode_bit
  localparam int unsigned     SELF_EN_BIT   = 5;      // self refresh in standby
  // status fields
  localparam int unsigned     ST_BUSY_BIT   = 0;
  localparam int unsigned     ST_SELF_BIT   = 1;
  localparam int unsigned     ST_PEND_BIT   = 2;
  // reset values
  localparam logic [6:0]      DRAM_CTRL_RST = 7'h00;
  localparam logic [5:0]      REF_CTRL_RST  = 6'h00;
  localparam logic [7:0]      COUNT_RST     = 8'h00;
  localparam logic [7:0]      CONST_RST     = 8'hFF;
  // row shift codes
  localparam logic [2:0]      SHIFT_11      = 3'h3;
  localparam logic [2:0]      SHIFT_8       = 3'h4;
  localparam logic [2:0]      SHIFT_9       = 3'h5;
  localparam logic [2:0]      SHIFT_10      = 3'h6;
  // refresh strobe timing in clk_sys cycles
  localparam logic [3:0]      CAS_LEAD_CYC  = 4'h1;   // cas low before ras falls
  localparam logic [3:0]      RAS_LOW_CYC   = 4'h4;   // ras low time of one refresh
  localparam logic [3:0]      PRECH_CYC     = 4'h2;   // both high before next cycle
  // refresh sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CAS, ST_RAS, ST_RECOVER} drc_state_e;
endpackage

// file: drc_dummy_unused.sv
// drc_dummy_unused: intentionally empty, no design content
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: drc_dram_model.sv
// drc_dram_model: passive dram that watches the strobes and measures refresh timing
`timescale 1ns/10ps
`default_nettype none
module drc_dram_model (
  input  wire logic clk_sys,    // system clock, strobes are sampled on it
  input  wire logic casN,       // column strobe, active low
  input  wire logic rasN,       // row strobe, active low
  output var  int   refCount,   // row strobe falls seen so far
  output var  int   lastPeriod, // cycles between the last two column falls
  output var  int   lastGap,    // cycles from column fall to row fall
  output var  int   lastRasLow, // cycles the row strobe stayed low
  output var  logic cbrBad      // row fell while column was still high
);
  int   cyc;                    // free cycle count
  int   casFall;                // cycle of the last column fall
  int   rasCnt;                 // running row-low length
  logic casP;                   // column strobe one edge ago
  logic rasP;                   // row strobe one edge ago

  // idle values, strobes assumed high before reset ends
  initial begin
    {refCount, lastPeriod, lastGap, lastRasLow, cyc, casFall, rasCnt} = '0;
    cbrBad = 1'b0;
    casP   = 1'b1;
    rasP   = 1'b1;
  end

  // edge detection on the falling clock edge: strobes are settled there and the bench
  // only reads the figures on rising edges, so no race on refCount
  always @(negedge clk_sys) begin
    cyc++;
    // a column fall starts a refresh cycle
    if (casP === 1'b1 && casN === 1'b0) begin
      lastPeriod = cyc - casFall;
      casFall    = cyc;
    end
    // a row fall must find the column already low, else the dram sees a normal activate
    if (rasP === 1'b1 && rasN === 1'b0) begin
      lastGap = cyc - casFall;
      if (casN !== 1'b0) cbrBad = 1'b1;
      refCount++;
      rasCnt = 0;
    end
    if (rasN === 1'b0) rasCnt++;
    // row rise closes the low period
    if (rasP === 1'b0 && rasN === 1'b1) lastRasLow = rasCnt;
    casP = casN;
    rasP = rasN;
  end
endmodule // drc_dram_model
`default_nettype wire

// file: drc_tb.sv
// drc_tb: self-checking bench for the row compare and refresh block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import drc_pkg::*;
  logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;           // apb byte address
  logic [31:0] pwdata, prdata;  // apb data
  logic [31:0] rd;              // last read word
  logic        accValid, accDram, standbyIn;
  logic [23:0] accAddr, a;      // access address and its scratch copy
  logic        sameRow_q, casN_q, rasN_q, dramHold_q, extHold_q, selfRef_q, cbrBad;
  logic [6:0]  prechSel_q;
  int          errors, tests_run, seed, refCount, lastPeriod, lastGap, lastRasLow;
  int          lb, r0, holdSeen, extSeen;
  int          codes[5] = '{0, 3, 4, 5, 6}; // one unused code plus every shift code

  drc_refresh_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .accValid(accValid), .accAddr(accAddr), .accDram(accDram),
    .standbyIn(standbyIn), .sameRow_q(sameRow_q), .prechSel_q(prechSel_q), .casN_q(casN_q),
    .rasN_q(rasN_q), .dramHold_q(dramHold_q), .extHold_q(extHold_q), .selfRef_q(selfRef_q));

  drc_dram_model i_dram (.clk_sys(clk_sys), .casN(casN_q), .rasN(rasN_q), .refCount(refCount),
    .lastPeriod(lastPeriod), .lastGap(lastGap), .lastRasLow(lastRasLow), .cbrBad(cbrBad));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // single exit point of the run
  task automatic tally_and_finish;
    $display("counts: %0d compares, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // compare a design value, four-state exact
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare a cycle figure measured by the dram model
  task automatic cmp_cyc(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; the request is held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one dram-space access, results are settled when the task returns
  task automatic acc(input logic [23:0] ad);
    @(posedge clk_sys);
    accValid <= 1'b1;
    accAddr <= ad;
    accDram <= 1'b1;
    @(posedge clk_sys);
    accValid <= 1'b0;
    accAddr <= ~ad;
    @(posedge clk_sys);
  endtask

  // expected precharge select for a shift code
  function automatic logic [6:0] prech(input int c, input logic [23:0] x);
    case (c)
      4: prech = x[15:9];
      5: prech = x[15:9] & 7'h7E;
      6: prech = x[15:9] & 7'h7C;
      default: prech = 7'h00;
    endcase
  endfunction

  // wait for cnt more refreshes, noting the hold outputs while the row is low
  task automatic wait_refresh(input int cnt);
    int k;
    k = 0;
    r0 = refCount;
    while (refCount < r0 + cnt && k < 2000) begin
      @(posedge clk_sys);
      k++;
      if (rasN_q === 1'b0 && dramHold_q === 1'b1) holdSeen++;
      if (rasN_q === 1'b0 && extHold_q === 1'b1) extSeen++;
    end
    if (refCount < r0 + cnt) begin
      errors++;
      tally_and_finish();
    end
  endtask

  // wait for self refresh to reach a level
  task automatic wait_self(input logic v);
    int k;
    k = 0;
    while (selfRef_q !== v && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    if (selfRef_q !== v) begin
      errors++;
      tally_and_finish();
    end
  endtask

  // main sequence
  initial begin
    seed = 32'h92416c48;
    {errors, tests_run, holdSeen, extSeen} = '0;
    {nrst, psel, penable, pwrite, accValid, accDram, standbyIn} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    accAddr = 24'h0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    // register reset values, read-back and an unmapped offset
    apb(1'b0, OFS_DRAM_CTRL, 32'h0);
    cmp_val(rd, {25'h0, DRAM_CTRL_RST});
    apb(1'b0, OFS_REF_CTRL, 32'h0);
    cmp_val(rd, {26'h0, REF_CTRL_RST});
    apb(1'b0, OFS_COUNT, 32'h0);
    cmp_val(rd, {24'h0, COUNT_RST});
    apb(1'b0, OFS_CONST, 32'h0);
    cmp_val(rd, {24'h0, CONST_RST});
    apb(1'b0, OFS_STATUS, 32'h0);
    cmp_val(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    cmp_val({31'h0, err}, 32'h1);
    a = 24'($random(seed));
    apb(1'b1, OFS_DRAM_CTRL, {25'h0, a[6:0]});
    apb(1'b0, OFS_DRAM_CTRL, 32'h0);
    cmp_val(rd, {25'h0, a[6:0]});
    $display("test registers done");
    // row compare boundary for every shift code and both bus widths, refresh off
    for (int i = 0; i < 5; i++) begin
      for (int b = 0; b < 2; b++) begin
        apb(1'b1, OFS_DRAM_CTRL, 32'(codes[i] | 8 | (b << 6)));
        lb = (codes[i] == 3 ? 11 : codes[i] + 4) + b;
        a = 24'($random(seed));
        acc(a);
        cmp_val(prechSel_q, prech(codes[i], a));
        acc(a);
        cmp_val(sameRow_q, codes[i] != 0);
        a[lb] = ~a[lb];
        acc(a);
        cmp_val(sameRow_q, 1'b0);
        a[lb-1] = ~a[lb-1];
        acc(a);
        cmp_val(sameRow_q, codes[i] != 0);
        cmp_val(prechSel_q, prech(codes[i], a));
      end
    end
    $display("test row_compare done");
    // refresh gating: enable off, no dram area, clock select zero
    apb(1'b1, OFS_CONST, 32'h3);
    apb(1'b1, OFS_DRAM_CTRL, 32'h8);
    r0 = refCount;
    apb(1'b1, OFS_REF_CTRL, 32'h1);
    repeat (100) @(posedge clk_sys);
    cmp_cyc(refCount, r0);
    apb(1'b1, OFS_DRAM_CTRL, 32'h0);
    apb(1'b1, OFS_REF_CTRL, 32'h9);
    repeat (100) @(posedge clk_sys);
    cmp_cyc(refCount, r0);
    apb(1'b1, OFS_REF_CTRL, 32'h8);
    apb(1'b1, OFS_DRAM_CTRL, 32'h8);
    apb(1'b1, OFS_COUNT, 32'h2);
    repeat (60) @(posedge clk_sys);
    apb(1'b0, OFS_COUNT, 32'h0);
    cmp_val(rd, 32'h2);
    cmp_cyc(refCount, r0);
    $display("test refresh_gating done");
    // periodic refresh for two clock selects and both refresh modes
    for (int s = 1; s < 3; s++) begin
      for (int m = 0; m < 2; m++) begin
        // counter and constant first, clock select last; period kept short for the run
        apb(1'b1, OFS_REF_CTRL, 32'h0);
        apb(1'b1, OFS_COUNT, 32'h0);
        apb(1'b1, OFS_CONST, 32'h7);
        apb(1'b1, OFS_REF_CTRL, 32'(s | 8 | (m << 4)));
        holdSeen = 0;
        extSeen = 0;
        wait_refresh(3);
        cmp_cyc(lastPeriod, 8 * (s == 1 ? 2 : 8));
        cmp_cyc(lastGap, int'(CAS_LEAD_CYC));
        cmp_cyc(lastRasLow, int'(RAS_LOW_CYC));
        cmp_val({31'h0, cbrBad}, 32'h0);
        cmp_cyc(int'(holdSeen > 0), 1);
        cmp_cyc(int'(extSeen > 0), m);
      end
    end
    $display("test periodic_refresh done");
    // self refresh across a standby period
    apb(1'b1, OFS_REF_CTRL, 32'h20);
    @(posedge clk_sys);
    standbyIn <= 1'b1;
    wait_self(1'b1);
    @(posedge clk_sys);
    cmp_val({30'h0, casN_q, rasN_q}, 32'h0);
    cmp_val({31'h0, cbrBad}, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    cmp_val({31'h0, rd[ST_SELF_BIT]}, 32'h1);
    standbyIn <= 1'b0;
    wait_self(1'b0);
    repeat (4) @(posedge clk_sys);
    cmp_val({30'h0, casN_q, rasN_q}, 32'h3);
    $display("test self_refresh done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
